// ===== logic/adcsq_control.v
// Purpose: register front end and scan sequencer for a 10-bit converter
// Assumes: converter core runs on clk_i; pin triggers are asynchronous
// Notes:   APB slave with zero wait states; result buffer up to four entries
`timescale 1ns/1ps
`include "adcsq_defs.vh"

module adcsq_control (
   input  wire        clk_i,           // system clock, 10 MHz
   input  wire        arst_n_i,        // async reset, active low
   input  wire        psel_i,          // apb select
   input  wire        penable_i,       // apb enable
   input  wire        pwrite_i,        // apb direction
   input  wire [11:0] paddr_i,         // apb byte address
   input  wire [31:0] pwdata_i,        // apb write data
   output reg  [31:0] prdata_o,        // apb read data
   output wire        pready_o,        // apb ready
   output wire        pslverr_o,       // apb error, unmapped
   input  wire        trig_pwm_i,      // audio pwm trigger pulse
   input  wire        trig_tmr1_i,     // timer1 trigger pulse
   input  wire        trig_tmr2_i,     // timer2 trigger pulse
   input  wire        trig_rtc_i,      // rtc trigger pulse
   input  wire        pin_pa6_i,       // port a pin 6, async
   input  wire        pin_pb4_i,       // port b pin 4, async
   input  wire [9:0]  conv_data_i,     // core result
   input  wire        conv_done_i,     // core done pulse
   output reg         conv_start_o,    // core start pulse
   output reg         sample_o,        // acquisition window
   output reg  [14:0] conv_chan_o,     // one-hot input mux
   output reg         conv_clk_o,      // divided converter clock
   output wire [7:0]  analog_pin_en_o, // pins in analog mode
   output wire        ref_pin_en_o,    // reference pin in analog use
   output wire        conv_irq_o       // conversion interrupt
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ACQ  = 2'h1;
   localparam [1:0] ST_CONV = 2'h2;
   localparam [1:0] ST_HOLD = 2'h3;
   localparam integer HALF_FAST_I = `ADCSQ_HALF_FAST;
   localparam integer HALF_SLOW_I = `ADCSQ_HALF_SLOW;
   localparam [4:0]   HALF_FAST   = HALF_FAST_I[4:0];
   localparam [4:0]   HALF_SLOW   = HALF_SLOW_I[4:0];

   reg  [15:0] ctrl0_q;
   reg  [15:0] chtrg_q;
   reg  [4:0]  bufctl_q;
   reg         done_q;
   reg  [9:0]  last_q;
   reg  [9:0]  buf_q [0:3];
   reg  [1:0]  wr_ptr_q;
   reg  [1:0]  rd_ptr_q;
   reg  [2:0]  fill_q;
   reg  [1:0]  state_q;
   reg  [14:0] pend_q;
   reg  [3:0]  chan_q;
   reg  [4:0]  acq_q;
   reg  [4:0]  div_q;
   reg         pa6_s1_q;
   reg         pa6_s2_q;
   reg         pa6_s3_q;
   reg         pb4_s1_q;
   reg         pb4_s2_q;
   reg         pb4_s3_q;

   wire        setup_w;
   wire        acc_w;
   wire        wr_w;
   wire        rd_w;
   wire        hit_ctrl0;
   wire        hit_chtrg;
   wire        hit_bufctl;
   wire        hit_result;
   wire        hit_status;
   wire        enable_w;
   wire [2:0]  trg_src_w;
   wire        result_rd_w;
   wire        pclr_w;
   wire [4:0]  half_w;
   wire        div_wrap_w;
   wire        tad_tick_w;
   wire [4:0]  acq_len_w;
   wire [9:0]  result_w;
   wire        store_w;
   wire [14:0] pend_left_w;
   reg  [2:0]  depth_w;
   reg         hw_trig_w;
   reg  [3:0]  first_w;
   reg  [9:0]  rd_val_w;
   integer     i;

   // apb decode
   assign setup_w    = psel_i & ~penable_i;
   assign acc_w      = psel_i & penable_i;
   assign wr_w       = acc_w & pwrite_i;
   assign rd_w       = acc_w & ~pwrite_i;
   assign hit_ctrl0  = (paddr_i == {`ADCSQ_IDX_CTRL0, 2'b00});
   assign hit_chtrg  = (paddr_i == {`ADCSQ_IDX_CHTRG, 2'b00});
   assign hit_bufctl = (paddr_i == {`ADCSQ_IDX_BUFCTL, 2'b00});
   assign hit_result = (paddr_i == {`ADCSQ_IDX_RESULT, 2'b00});
   assign hit_status = (paddr_i == {`ADCSQ_IDX_STATUS, 2'b00});
   assign pready_o   = 1'b1;
   assign pslverr_o  = acc_w & ~(hit_ctrl0 | hit_chtrg | hit_bufctl | hit_result | hit_status);

   assign enable_w    = ctrl0_q[`ADCSQ_EN_BIT];
   assign trg_src_w   = ctrl0_q[`ADCSQ_TRG_LO+2:`ADCSQ_TRG_LO];
   assign result_rd_w = rd_w & hit_result;
   assign pclr_w      = wr_w & hit_bufctl & pwdata_i[`ADCSQ_PCLR_BIT];

   // pin outputs follow channel and reference bits
   assign analog_pin_en_o = chtrg_q[7:0];
   assign ref_pin_en_o    = ctrl0_q[`ADCSQ_VREF_BIT];
   assign conv_irq_o      = done_q & ctrl0_q[`ADCSQ_IEN_BIT];

   // buffer depth from size, ping-pong and enable
   always @* begin
      if (!bufctl_q[`ADCSQ_BUFEN_BIT]) begin
         depth_w = 3'h0;
      end else begin
         depth_w = bufctl_q[`ADCSQ_BSIZE_BIT] ? 3'h4 : 3'h2;
         if (bufctl_q[`ADCSQ_PPONG_BIT]) begin
            depth_w = {1'b0, depth_w[2:1]};
         end
      end
   end

   // hardware trigger select
   always @* begin
      case (trg_src_w)
         `ADCSQ_TRG_PWM:  hw_trig_w = trig_pwm_i;
         `ADCSQ_TRG_TMR1: hw_trig_w = trig_tmr1_i;
         `ADCSQ_TRG_TMR2: hw_trig_w = trig_tmr2_i;
         `ADCSQ_TRG_RTC:  hw_trig_w = trig_rtc_i;
         `ADCSQ_TRG_PA6:  hw_trig_w = pa6_s2_q & ~pa6_s3_q;
         `ADCSQ_TRG_SW:   hw_trig_w = 1'b0;
         default:         hw_trig_w = pb4_s2_q & ~pb4_s3_q;
      endcase
   end

   // lowest pending channel
   always @* begin
      first_w = 4'h0;
      for (i = 14; i >= 0; i = i - 1) begin
         if (pend_q[i]) begin
            first_w = i[3:0];
         end
      end
   end

   // read data mux for the result register
   always @* begin
      if (depth_w == 3'h0) begin
         rd_val_w = last_q;
      end else begin
         rd_val_w = buf_q[rd_ptr_q];
      end
   end

   // pin trigger synchronisers and edge history
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pa6_s1_q <= 1'b0;
         pa6_s2_q <= 1'b0;
         pa6_s3_q <= 1'b0;
         pb4_s1_q <= 1'b0;
         pb4_s2_q <= 1'b0;
         pb4_s3_q <= 1'b0;
      end else begin
         pa6_s1_q <= pin_pa6_i;
         pa6_s2_q <= pa6_s1_q;
         pa6_s3_q <= pa6_s2_q;
         pb4_s1_q <= pin_pb4_i;
         pb4_s2_q <= pb4_s1_q;
         pb4_s3_q <= pb4_s2_q;
      end
   end

   // converter clock divider
   assign half_w     = ctrl0_q[`ADCSQ_CLKSEL_BIT] ? HALF_FAST : HALF_SLOW;
   assign div_wrap_w = (div_q >= half_w - 5'h1);
   assign tad_tick_w = div_wrap_w & ~conv_clk_o;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q      <= 5'h00;
         conv_clk_o <= 1'b0;
      end else if (div_wrap_w) begin
         div_q      <= 5'h00;
         conv_clk_o <= ~conv_clk_o;
      end else begin
         div_q      <= div_q + 5'h01;
      end
   end

   // acquisition length in converter clocks: 2 << code
   assign acq_len_w = 5'h02 << ctrl0_q[`ADCSQ_ACQ_LO+1:`ADCSQ_ACQ_LO];

   // result formatting and scan bookkeeping
   assign result_w = ctrl0_q[`ADCSQ_SIGN_BIT] ? (conv_data_i ^ `ADCSQ_SIGN_XOR)
                                               : conv_data_i;
   assign store_w     = (state_q == ST_CONV) & conv_done_i;
   assign pend_left_w = pend_q & ~(15'h0001 << first_w);

   // control registers
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl0_q  <= `ADCSQ_RST_CTRL0;
         chtrg_q  <= `ADCSQ_RST_CHTRG;
         bufctl_q <= `ADCSQ_RST_BUFCTL;
      end else begin
         if (wr_w & hit_ctrl0) begin
            ctrl0_q <= pwdata_i[15:0] & 16'hf731;               // unused bits read zero
         end
         if (wr_w & hit_chtrg & enable_w) begin
            chtrg_q <= pwdata_i[15:0];
         end else if (store_w & (pend_left_w == 15'h0000)) begin
            chtrg_q[`ADCSQ_SOFTWARE_TRIGGER_BIT] <= 1'b0;
         end
         if (wr_w & hit_bufctl) begin
            bufctl_q <= {1'b0, pwdata_i[3:0]};
         end
      end
   end

   // done flag: set wins over the write-one clear
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_q <= 1'b0;
      end else if (store_w) begin
         done_q <= 1'b1;
      end else if (wr_w & hit_status & pwdata_i[0]) begin
         done_q <= 1'b0;
      end
   end

   // result buffer entries
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_buf
         always @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               buf_q[g] <= 10'h000;
            end else if (store_w & (depth_w != 3'h0) & (wr_ptr_q == g)) begin
               buf_q[g] <= result_w;
            end
         end
      end
   endgenerate

   // buffer pointers, fill level and direct result
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_q   <= 10'h000;
         wr_ptr_q <= 2'h0;
         rd_ptr_q <= 2'h0;
         fill_q   <= 3'h0;
      end else if (pclr_w) begin
         wr_ptr_q <= 2'h0;
         rd_ptr_q <= 2'h0;
         fill_q   <= 3'h0;
      end else begin
         if (store_w) begin
            last_q <= result_w;
         end
         if (store_w & (depth_w != 3'h0)) begin
            wr_ptr_q <= ({1'b0, wr_ptr_q} + 3'h1 >= depth_w) ? 2'h0 : wr_ptr_q + 2'h1;
         end
         if (result_rd_w & (depth_w != 3'h0)) begin
            rd_ptr_q <= ({1'b0, rd_ptr_q} + 3'h1 >= depth_w) ? 2'h0 : rd_ptr_q + 2'h1;
         end
         if (store_w & ~(result_rd_w & fill_q != 3'h0) & (fill_q < depth_w)) begin
            fill_q <= fill_q + 3'h1;
         end else if (~store_w & result_rd_w & (fill_q != 3'h0)) begin
            fill_q <= fill_q - 3'h1;
         end
      end
   end

   // scan sequencer
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q      <= ST_IDLE;
         pend_q       <= 15'h0000;
         chan_q       <= 4'h0;
         acq_q        <= 5'h00;
         sample_o     <= 1'b0;
         conv_start_o <= 1'b0;
         conv_chan_o  <= 15'h0000;
      end else begin
         conv_start_o <= 1'b0;
         if (!enable_w) begin
            state_q     <= ST_IDLE;
            sample_o    <= 1'b0;
            conv_chan_o <= 15'h0000;
            pend_q      <= 15'h0000;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if ((chtrg_q[14:0] != 15'h0000) &&
                      ((trg_src_w == `ADCSQ_TRG_SW) ? chtrg_q[`ADCSQ_SOFTWARE_TRIGGER_BIT]
                                                    : hw_trig_w)) begin
                     pend_q  <= chtrg_q[14:0];
                     chan_q  <= 4'hf;                           // first channel never waits
                     state_q <= ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  if (~bufctl_q[`ADCSQ_RDGATE_BIT] | (chan_q == 4'hf) | result_rd_w) begin
                     chan_q      <= first_w;
                     conv_chan_o <= 15'h0001 << first_w;
                     acq_q       <= 5'h00;
                     sample_o    <= 1'b1;
                     state_q     <= ST_ACQ;
                  end
               end
               ST_ACQ: begin
                  if (tad_tick_w) begin
                     if (acq_q == acq_len_w - 5'h01) begin
                        sample_o     <= 1'b0;
                        conv_start_o <= 1'b1;
                        state_q      <= ST_CONV;
                     end else begin
                        acq_q <= acq_q + 5'h01;
                     end
                  end
               end
               ST_CONV: begin
                  if (conv_done_i) begin
                     pend_q <= pend_left_w;
                     if (pend_left_w == 15'h0000) begin
                        conv_chan_o <= 15'h0000;
                        chan_q      <= 4'hf;
                        state_q     <= ST_IDLE;
                     end else begin
                        state_q     <= ST_HOLD;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // apb read data captured in the setup cycle
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_o <= 32'h00000000;
      end else if (setup_w & ~pwrite_i) begin
         if (hit_ctrl0) begin
            prdata_o <= {16'h0000, ctrl0_q};
         end else if (hit_chtrg) begin
            prdata_o <= {16'h0000, chtrg_q};
         end else if (hit_bufctl) begin
            prdata_o <= {27'h0000000, bufctl_q};
         end else if (hit_result) begin
            prdata_o <= {16'h0000, rd_val_w[9:2], rd_val_w[1:0], 6'h00};
         end else if (hit_status) begin
            prdata_o <= {24'h000000, state_q, fill_q, 2'h0, done_q};
         end else begin
            prdata_o <= 32'h00000000;
         end
      end
   end

endmodule // adcsq_control

// ===== logic/adcsq_defs.vh
// Purpose: constants for the converter sequencer control block
// Assumes: 10 MHz system clock; APB byte address is four times the register index
// Notes:   definitions only
`ifndef ADCSQ_DEFS_VH
`define ADCSQ_DEFS_VH

// register indices; byte address = index * 4
`define ADCSQ_IDX_CTRL0    10'h040
`define ADCSQ_IDX_CHTRG    10'h041
`define ADCSQ_IDX_BUFCTL   10'h042
`define ADCSQ_IDX_RESULT   10'h044
`define ADCSQ_IDX_STATUS   10'h046

// reset values
`define ADCSQ_RST_CTRL0    16'h0000
`define ADCSQ_RST_CHTRG    16'h0000
`define ADCSQ_RST_BUFCTL   5'h00

// control zero fields
`define ADCSQ_CLKSEL_BIT   0
`define ADCSQ_ACQ_LO       4
`define ADCSQ_TRG_LO       8
`define ADCSQ_SIGN_BIT     12
`define ADCSQ_VREF_BIT     13
`define ADCSQ_IEN_BIT      14
`define ADCSQ_EN_BIT       15

// channel and trigger fields
`define ADCSQ_SOFTWARE_TRIGGER_BIT    15

// buffer control fields
`define ADCSQ_BSIZE_BIT    0
`define ADCSQ_PPONG_BIT    1
`define ADCSQ_BUFEN_BIT    2
`define ADCSQ_RDGATE_BIT   3
`define ADCSQ_PCLR_BIT     4

// trigger source codes
`define ADCSQ_TRG_SW       3'h0
`define ADCSQ_TRG_PWM      3'h1
`define ADCSQ_TRG_TMR1     3'h2
`define ADCSQ_TRG_TMR2     3'h3
`define ADCSQ_TRG_RTC      3'h4
`define ADCSQ_TRG_PA6      3'h5

// signed output flip constant
`define ADCSQ_SIGN_XOR     10'h200

// timing: system clock and converter clock periods in ns
`define ADCSQ_CLK_NS       100
`define ADCSQ_TAD_FAST_NS  1000
`define ADCSQ_TAD_SLOW_NS  1953
`define ADCSQ_HALF_FAST    (`ADCSQ_TAD_FAST_NS / 2 / `ADCSQ_CLK_NS)
`define ADCSQ_HALF_SLOW    (`ADCSQ_TAD_SLOW_NS / 2 / `ADCSQ_CLK_NS)

`endif

// ===== verification/adcsq_core_model.sv
// Purpose: behavioural converter core beside the sequencer
// Assumes: one conversion per start pulse
// Notes:   data lines toggle while no result is offered
`timescale 1ns/1ps
module adcsq_core_model (
   input  wire        clk_i,        // clock
   input  wire        arst_n_i,     // reset, active low
   input  wire        slow_i,       // long conversion when high
   input  wire        conv_start_i, // start pulse
   input  wire [14:0] conv_chan_i,  // one-hot channel
   output reg  [9:0]  conv_data_o,  // result code
   output reg         conv_done_o   // done pulse
);
   reg [5:0] cnt_q;
   reg [3:0] idx_q;
   integer   k;
   // count a conversion down, then offer the code for one cycle
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 6'h00;
         idx_q <= 4'h0;
         conv_done_o <= 1'b0;
         conv_data_o <= 10'h000;
      end else begin
         conv_done_o <= 1'b0;
         conv_data_o <= ~conv_data_o;
         if (conv_start_i) begin
            cnt_q <= slow_i ? 6'h28 : 6'h02;
            for (k = 0; k < 15; k = k + 1)
               if (conv_chan_i[k]) idx_q <= k[3:0];
         end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               conv_done_o <= 1'b1;
               conv_data_o <= {idx_q + 4'h9, 6'h25};
            end
         end
      end
   end
endmodule // adcsq_core_model

// ===== verification/adcsq_sva.sv
// Purpose: port assertions for the converter sequencer
// Assumes: zero wait apb slave; byte address is index times four
// Notes:   register shadows are rebuilt from apb writes
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module adcsq_sva (
   input wire        clk_i,           // clock
   input wire        arst_n_i,        // reset, active low
   input wire        psel_i,          // apb select
   input wire        penable_i,       // apb enable
   input wire        pwrite_i,        // apb direction
   input wire [11:0] paddr_i,         // apb address
   input wire [31:0] pwdata_i,        // apb write data
   input wire [31:0] prdata_o,        // apb read data
   input wire        pready_o,        // apb ready
   input wire        pslverr_o,       // apb error
   input wire        conv_done_i,     // core done
   input wire        conv_start_o,    // core start
   input wire        sample_o,        // acquisition window
   input wire [14:0] conv_chan_o,     // channel mux
   input wire        conv_clk_o,      // converter clock
   input wire [7:0]  analog_pin_en_o, // analog pins
   input wire        ref_pin_en_o,    // reference pin
   input wire        conv_irq_o       // interrupt
);
   localparam [11:0] A0 = {`ADCSQ_IDX_CTRL0, 2'b00};
   localparam [11:0] A1 = {`ADCSQ_IDX_CHTRG, 2'b00};
   localparam [11:0] AR = {`ADCSQ_IDX_RESULT, 2'b00};
   wire wr = psel_i & penable_i & pwrite_i & pready_o;
   wire w0 = wr & (paddr_i == A0);
   wire map = (paddr_i == A0) | (paddr_i == A1) | (paddr_i == {`ADCSQ_IDX_BUFCTL, 2'b00})
            | (paddr_i == AR) | (paddr_i == {`ADCSQ_IDX_STATUS, 2'b00});
   reg  [15:0] c0_q;
   reg  [7:0]  ch_q;
   reg  [4:0]  st_q;
   // shadows; st_q counts cycles since enable or clock select changed
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         c0_q <= 16'h0000;
         ch_q <= 8'h00;
         st_q <= 5'h00;
      end else begin
         if (w0) c0_q <= pwdata_i[15:0];
         if (wr && paddr_i == A1 && c0_q[15]) ch_q <= pwdata_i[7:0];
         if (w0 && (pwdata_i[15] != c0_q[15] || pwdata_i[0] != c0_q[0])) st_q <= 5'h00;
         else if (st_q != 5'h1f) st_q <= st_q + 5'h01;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_ready; pready_o; endproperty
   property p_err; psel_i && penable_i |-> pslverr_o == !map; endproperty
   property p_irq_set; conv_done_i && c0_q[14] && !w0 |=> conv_irq_o; endproperty
   property p_irq_gate; !c0_q[14] |-> !conv_irq_o; endproperty
   property p_ref; ref_pin_en_o == c0_q[13]; endproperty
   property p_pins; analog_pin_en_o == ch_q; endproperty
   property p_onehot; sample_o |-> $onehot(conv_chan_o); endproperty
   property p_acq;
      $rose(sample_o) && c0_q[5:4] == 2'b00 && c0_q[0] |->
         !conv_start_o [*8] ##[4:13] conv_start_o;
   endproperty
   property p_clk_fast;
      sample_o && c0_q[15] && c0_q[0] && st_q == 5'h1f && $changed(conv_clk_o) |=>
         $stable(conv_clk_o) [*4] ##1 $changed(conv_clk_o);
   endproperty
   property p_clk_slow;
      sample_o && c0_q[15] && !c0_q[0] && st_q == 5'h1f && $changed(conv_clk_o) |=>
         $stable(conv_clk_o) [*8] ##1 $changed(conv_clk_o);
   endproperty
   property p_res;
      psel_i && penable_i && !pwrite_i && paddr_i == AR |->
         prdata_o[5:0] == 6'h00 && prdata_o[31:16] == 16'h0000;
   endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_err: assert property (p_err) else $error("error flag wrong");
   a_irq_set: assert property (p_irq_set) else $error("no interrupt");
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
   a_ref: assert property (p_ref) else $error("reference pin wrong");
   a_pins: assert property (p_pins) else $error("analog pins wrong");
   a_onehot: assert property (p_onehot) else $error("channel not one-hot");
   a_acq: assert property (p_acq) else $error("acquisition length");
   a_clk_fast: assert property (p_clk_fast) else $error("fast clock");
   a_clk_slow: assert property (p_clk_slow) else $error("slow clock");
   a_res: assert property (p_res) else $error("result layout");
   c_start: cover property ($rose(conv_start_o));
   c_irq: cover property ($rose(conv_irq_o));
   c_err: cover property (pslverr_o);
endmodule // adcsq_sva

bind adcsq_control adcsq_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .conv_done_i(conv_done_i), .conv_start_o(conv_start_o), .sample_o(sample_o),
   .conv_chan_o(conv_chan_o), .conv_clk_o(conv_clk_o), .analog_pin_en_o(analog_pin_en_o),
   .ref_pin_en_o(ref_pin_en_o), .conv_irq_o(conv_irq_o));

// ===== verification/tb.sv
// Purpose: register-level test of the converter sequencer
// Assumes: zero wait apb slave; core model answers each start
// Notes:   expected codes follow the model's channel pattern
`timescale 1ns/1ps
`include "adcsq_defs.vh"
module tb;
   localparam [11:0] A0 = {`ADCSQ_IDX_CTRL0, 2'b00};
   localparam [11:0] A1 = {`ADCSQ_IDX_CHTRG, 2'b00};
   localparam [11:0] A2 = {`ADCSQ_IDX_BUFCTL, 2'b00};
   localparam [11:0] AR = {`ADCSQ_IDX_RESULT, 2'b00};
   localparam [11:0] AS = {`ADCSQ_IDX_STATUS, 2'b00};
   reg         clk_i, arst_n_i, psel_i, penable_i, pwrite_i, slow_i, e;
   reg  [11:0] paddr_i;
   reg  [31:0] pwdata_i, r;
   reg  [5:0]  src_q;
   wire [31:0] prdata_o;
   wire [14:0] conv_chan_o;
   wire [9:0]  conv_data_i;
   wire [7:0]  analog_pin_en_o;
   wire        pready_o, pslverr_o, conv_done_i, conv_start_o, sample_o;
   wire        conv_clk_o, ref_pin_en_o, conv_irq_o;
   integer     num_errors, tests_run, i, c;
   integer     cyc = 0;
   adcsq_control dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .trig_pwm_i(src_q[0]), .trig_tmr1_i(src_q[1]), .trig_tmr2_i(src_q[2]),
      .trig_rtc_i(src_q[3]), .pin_pa6_i(src_q[4]), .pin_pb4_i(src_q[5]),
      .conv_data_i(conv_data_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
      .sample_o(sample_o), .conv_chan_o(conv_chan_o), .conv_clk_o(conv_clk_o),
      .analog_pin_en_o(analog_pin_en_o), .ref_pin_en_o(ref_pin_en_o), .conv_irq_o(conv_irq_o));
   adcsq_core_model u_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .slow_i(slow_i),
      .conv_start_i(conv_start_o), .conv_chan_i(conv_chan_o), .conv_data_o(conv_data_i),
      .conv_done_o(conv_done_i));
   // 10 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   function [9:0] cd(input [3:0] k);
      cd = {k + 4'h9, 6'h25};
   endfunction
   function [31:0] pk(input [9:0] v);
      pk = {16'h0000, v, 6'h00};
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // one apb transfer; data taken at the ready edge
   task xfer(input [11:0] a, input w, input [31:0] d);
      begin
         @(posedge clk_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1'b1;
         @(posedge clk_i);
         while (pready_o !== 1'b1) @(posedge clk_i);
         r = prdata_o;
         e = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] x);
      begin
         xfer(a, 1'b0, 32'h0);
         check(r, x);
      end
   endtask
   // poll one bit until it reads v
   task poll(input [11:0] a, input integer b, input v);
      begin
         i = 0;
         do begin
            xfer(a, 1'b0, 32'h0);
            i = i + 1;
         end while (r[b] !== v && i < 300);
      end
   endtask
   task pulse(input integer k);
      begin
         @(posedge clk_i);
         src_q <= 6'h01 << ((k == 7) ? 5 : k - 1);
         @(posedge clk_i);
         src_q <= 6'h00;
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d of %0d checks", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      num_errors = 0;
      tests_run = 0;
      {arst_n_i, psel_i, penable_i, pwrite_i, slow_i, src_q} = 11'h000;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rdchk(A0, 32'h0);
      rdchk(A1, 32'h0);
      rdchk(A2, 32'h0);
      rdchk(AR, 32'h0);
      xfer(A1, 1'b1, 32'h8003);
      rdchk(A1, 32'h0);
      xfer(A0, 1'b1, 32'he001);
      xfer(A1, 1'b1, 32'h8085);
      @(negedge clk_i);
      check({31'h0, ref_pin_en_o}, 32'h1);
      check({24'h0, analog_pin_en_o}, 32'h85);
      poll(A1, 15, 1'b0);
      check(r, 32'h0085);
      check({31'h0, conv_irq_o}, 32'h1);
      rdchk(AR, pk(cd(4'h7)));
      xfer(A0, 1'b1, 32'hf011);
      xfer(AS, 1'b1, 32'h1);
      xfer(A1, 1'b1, 32'h8002);
      poll(A1, 15, 1'b0);
      rdchk(AR, pk(cd(4'h1) ^ `ADCSQ_SIGN_XOR));
      xfer(A0, 1'b1, 32'hb011);
      @(negedge clk_i);
      check({31'h0, conv_irq_o}, 32'h0);
      xfer(AS, 1'b0, 32'h0);
      check({31'h0, r[0]}, 32'h1);
      // hardware sources, slow core, wrong source first
      slow_i <= 1'b1;
      for (c = 1; c < 8; c = c + 1) begin
         xfer(A0, 1'b1, 32'h8000 | (c << 8));
         xfer(AS, 1'b1, 32'h1);
         xfer(A1, 1'b1, 32'h0001);
         pulse(c == 1 ? 2 : 1);
         repeat (150) @(posedge clk_i);
         xfer(AS, 1'b0, 32'h0);
         check({31'h0, r[0]}, 32'h0);
         pulse(c);
         poll(AS, 0, 1'b1);
         check({31'h0, r[0]}, 32'h1);
      end
      // four-level buffer keeps scan order
      slow_i <= 1'b0;
      xfer(A0, 1'b1, 32'h8001);
      xfer(A2, 1'b1, 32'h15);
      rdchk(A2, 32'h5);
      xfer(A1, 1'b1, 32'h800b);
      poll(A1, 15, 1'b0);
      rdchk(AS, 32'h19);
      xfer(A2, 1'b1, 32'h15);
      rdchk(AS, 32'h01);
      rdchk(AR, pk(cd(4'h0)));
      rdchk(AR, pk(cd(4'h1)));
      rdchk(AR, pk(cd(4'h3)));
      // read-gated scan stalls until the result is read
      xfer(A2, 1'b1, 32'h1d);
      xfer(A1, 1'b1, 32'h8003);
      repeat (150) @(posedge clk_i);
      rdchk(A1, 32'h8003);
      rdchk(AR, pk(cd(4'h0)));
      poll(A1, 15, 1'b0);
      rdchk(AR, pk(cd(4'h1)));
      // ping-pong gives two levels: third result wraps onto slot 0
      xfer(A2, 1'b1, 32'h17);
      xfer(A1, 1'b1, 32'h8203);
      poll(A1, 15, 1'b0);
      rdchk(AR, pk(cd(4'h9)));
      rdchk(AR, pk(cd(4'h1)));
      xfer(12'h1fc, 1'b0, 32'h0);
      check(r, 32'h0);
      check({31'h0, e}, 32'h1);
      give_verdict;
   end
endmodule // tb
